// File: ptptc_defines.svh
// Register offsets, field positions and reset values of the pin trigger/timestamp control
`ifndef PTPTC_DEFINES_SVH
`define PTPTC_DEFINES_SVH
`define PTPTC_ADDR_INDEX 12'h520
`define PTPTC_ADDR_CTRL 12'h52c
`define PTPTC_ADDR_TGT_NS 12'h530
`define PTPTC_ADDR_TGT_S 12'h534
`define PTPTC_ADDR_OPTION 12'h538
`define PTPTC_ADDR_ERROR 12'h53c
`define PTPTC_ADDR_COUNT 12'h540
`define PTPTC_IDX_TRIG_LSB 0
`define PTPTC_IDX_TRIG_MSB 1
`define PTPTC_IDX_TS_BIT 8
`define PTPTC_BIT_OUT_SEL 8
`define PTPTC_BIT_PIN_IN 7
`define PTPTC_BIT_PIN_DIR 6
`define PTPTC_BIT_IRQ_EN 5
`define PTPTC_BIT_RUNNING 4
`define PTPTC_BIT_ARM 3
`define PTPTC_BIT_TRIG_CLR 2
`define PTPTC_BIT_CAP_ARM 1
`define PTPTC_BIT_CAP_CLR 0
`define PTPTC_BIT_FIRE_NOW 25
`define PTPTC_NS_MSB 29
`define PTPTC_ERR_LSB 16
`define PTPTC_CNT_OVF_BIT 8
`define PTPTC_ZERO32 32'h0000_0000
`define PTPTC_NUM_TRIG 4
`define PTPTC_NUM_TS 2
`define PTPTC_HTRANS_NONSEQ 2'h2
`endif

// File: ptptc_pkg.sv
// Types shared by the pin trigger/timestamp control block
package ptptc_pkg;
  typedef enum logic [1:0] {PTPTC_IDLE, PTPTC_WAIT, PTPTC_FIRED} ptptc_trig_type;
  typedef logic [7:0] ptptc_count_type;
endpackage

// File: ptptc_ctl.sv
// AHB-Lite register block for pin trigger output units and timestamp input units
`timescale 1ns/1ps
`default_nettype none
`include "ptptc_defines.svh"

// Notes on behaviour
// - Indexed fields go to trigger unit at pointer bits 1:0 or capture unit at bit 8.
// - Source select 1 drives pin combinationally; 0 (default) from a flip-flop.
// - Pin input level is readable, read-only.
// - Direction 1 makes the pin a capture input; 0, default, an event output.
// - Capture interrupt only when that unit's enable bit is set; resets to 0.
// - Running bit reads 1 while armed without error, 0 once done.
// - Writing 1 to arm enables the trigger unit; cleared when it fires.
// - Trigger soft-clear forces the unit idle with default settings.
// - Writing 1 to capture arm enables unit and zeroes its event count.
// - Writing 0 to capture arm disables unit, clears valid and overflow flags.
// - Capture soft-clear returns the unit to idle defaults; reads 0.
// - Per-unit nanosecond target, reset 0, bits 31:30 read zero.
// - Per-unit 32-bit seconds target, reset 0.
// - Target words reach only the unit chosen by the trigger pointer.
// - Late-target error flag clears when software writes 0 to arm.
// - Fire-now with a past target fires at once; a future target is waited for; a past target without fire-now never fires.
module ptptc_ctl (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] SYS_TIME_SEC,
  input wire logic [29:0] SYS_TIME_NS,
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE,
  input wire logic [1:0] CAPTURE_EVENT,
  input wire logic [1:0] CAPTURE_STORED,
  output logic [1:0] CAPTURE_IRQ
);
  localparam int NT = `PTPTC_NUM_TRIG;
  localparam int NC = `PTPTC_NUM_TS;

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else if (HREADY) begin
      wr_pend_reg <= HSEL && (HTRANS == `PTPTC_HTRANS_NONSEQ) && HWRITE;
      addr_reg <= HADDR[11:0];
    end else begin
      wr_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every register answers in its data phase, so no wait state is ever needed
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ----------------------------------------------------------------
  // Write strobes for the data phase
  // ----------------------------------------------------------------
  logic wr_idx;
  logic wr_ctrl;
  logic wr_ns;
  logic wr_s;
  logic wr_opt;
  logic wr_err;
  assign wr_idx = wr_pend_reg && (addr_reg == `PTPTC_ADDR_INDEX);
  assign wr_ctrl = wr_pend_reg && (addr_reg == `PTPTC_ADDR_CTRL);
  assign wr_ns = wr_pend_reg && (addr_reg == `PTPTC_ADDR_TGT_NS);
  assign wr_s = wr_pend_reg && (addr_reg == `PTPTC_ADDR_TGT_S);
  assign wr_opt = wr_pend_reg && (addr_reg == `PTPTC_ADDR_OPTION);
  assign wr_err = wr_pend_reg && (addr_reg == `PTPTC_ADDR_ERROR);

  // ----------------------------------------------------------------
  // Index and shared control bits
  // ----------------------------------------------------------------
  logic [1:0] trig_ptr_reg;
  logic ts_ptr_reg;
  logic out_sel_reg;
  logic pin_dir_reg;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      trig_ptr_reg <= 2'h0;
      ts_ptr_reg <= 1'b0;
    end else if (wr_idx) begin
      trig_ptr_reg <= HWDATA[`PTPTC_IDX_TRIG_MSB:`PTPTC_IDX_TRIG_LSB];
      ts_ptr_reg <= HWDATA[`PTPTC_IDX_TS_BIT];
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      out_sel_reg <= 1'b0;
      pin_dir_reg <= 1'b0;
    end else if (wr_ctrl) begin
      out_sel_reg <= HWDATA[`PTPTC_BIT_OUT_SEL];
      pin_dir_reg <= HWDATA[`PTPTC_BIT_PIN_DIR];
    end
  end

  // ----------------------------------------------------------------
  // Trigger output units
  // ----------------------------------------------------------------
  logic [NT-1:0] arm_reg;
  logic [NT-1:0] err_reg;
  logic [NT-1:0] now_reg;
  logic [NT-1:0] hit;
  logic [NT-1:0] late;
  logic [29:0] tns_reg [NT];
  logic [31:0] ts_reg [NT];
  ptptc_pkg::ptptc_trig_type st_reg [NT];

  for (genvar u = 0; u < NT; u++) begin : g_trig
    logic sel;
    logic sw_clr;
    assign sel = (trig_ptr_reg == 2'(u));
    assign sw_clr = wr_ctrl && sel && HWDATA[`PTPTC_BIT_TRIG_CLR];
    // Time reached: seconds first, then nanoseconds
    assign hit[u] = (SYS_TIME_SEC > ts_reg[u]) ||
                    ((SYS_TIME_SEC == ts_reg[u]) && (SYS_TIME_NS >= tns_reg[u]));
    // Time strictly past the target; only looked at when the unit is armed
    assign late[u] = (SYS_TIME_SEC > ts_reg[u]) ||
                     ((SYS_TIME_SEC == ts_reg[u]) && (SYS_TIME_NS > tns_reg[u]));

    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST || sw_clr) begin
        tns_reg[u] <= 30'h0000_0000;
        ts_reg[u] <= `PTPTC_ZERO32;
        now_reg[u] <= 1'b0;
      end else begin
        if (wr_ns && sel) begin
          tns_reg[u] <= HWDATA[`PTPTC_NS_MSB:0];
        end
        if (wr_s && sel) begin
          ts_reg[u] <= HWDATA;
        end
        if (wr_opt && sel) begin
          now_reg[u] <= HWDATA[`PTPTC_BIT_FIRE_NOW];
        end
      end
    end

    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST || sw_clr) begin
        arm_reg[u] <= 1'b0;
        err_reg[u] <= 1'b0;
        st_reg[u] <= ptptc_pkg::PTPTC_IDLE;
      end else if (wr_ctrl && sel) begin
        arm_reg[u] <= HWDATA[`PTPTC_BIT_ARM];
        st_reg[u] <= HWDATA[`PTPTC_BIT_ARM] ? ptptc_pkg::PTPTC_WAIT : ptptc_pkg::PTPTC_IDLE;
        // Lateness is judged once, at arming: system time that later steps over
        // the target in one stride must still fire the unit
        if (HWDATA[`PTPTC_BIT_ARM]) begin
          err_reg[u] <= late[u] && !now_reg[u];
        end else begin
          err_reg[u] <= 1'b0;
        end
      end else begin
        case (st_reg[u])
          ptptc_pkg::PTPTC_IDLE: begin
          end
          ptptc_pkg::PTPTC_WAIT: begin
            // A unit flagged late stays armed but never fires
            if (hit[u] && !err_reg[u]) begin
              arm_reg[u] <= 1'b0;
              st_reg[u] <= ptptc_pkg::PTPTC_FIRED;
            end
          end
          ptptc_pkg::PTPTC_FIRED: begin
            st_reg[u] <= ptptc_pkg::PTPTC_IDLE;
          end
          default: begin
            st_reg[u] <= ptptc_pkg::PTPTC_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin output: one-cycle pulse on each fire of the selected unit
  // ----------------------------------------------------------------
  logic pin_comb;
  logic pin_flop_reg;
  logic fire_sel;
  assign fire_sel = (st_reg[trig_ptr_reg] == ptptc_pkg::PTPTC_FIRED);
  assign pin_comb = fire_sel;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pin_flop_reg <= 1'b0;
    end else begin
      pin_flop_reg <= pin_comb;
    end
  end
  // A capture pin has its enable low, so a fire there never reaches the pad
  assign PIN_OUT = out_sel_reg ? pin_comb : pin_flop_reg;
  assign PIN_OE = !pin_dir_reg;

  // ----------------------------------------------------------------
  // Timestamp input units
  // ----------------------------------------------------------------
  logic [NC-1:0] cap_arm_reg;
  logic [NC-1:0] irq_en_reg;
  logic [NC-1:0] valid_reg;
  logic [NC-1:0] ovf_reg;
  ptptc_pkg::ptptc_count_type cnt_reg [NC];

  for (genvar c = 0; c < NC; c++) begin : g_cap
    logic sel;
    logic clr;
    logic ev;
    assign sel = (ts_ptr_reg == 1'(c));
    assign clr = wr_ctrl && sel && HWDATA[`PTPTC_BIT_CAP_CLR];
    // Events count only while the pin is a capture input
    assign ev = cap_arm_reg[c] && pin_dir_reg && CAPTURE_EVENT[c];
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST || clr) begin
        cap_arm_reg[c] <= 1'b0;
        irq_en_reg[c] <= 1'b0;
        valid_reg[c] <= 1'b0;
        ovf_reg[c] <= 1'b0;
        cnt_reg[c] <= 8'h00;
      end else if (wr_ctrl && sel) begin
        cap_arm_reg[c] <= HWDATA[`PTPTC_BIT_CAP_ARM];
        irq_en_reg[c] <= HWDATA[`PTPTC_BIT_IRQ_EN];
        // An event landing together with the write still counts: set wins over clear
        if (HWDATA[`PTPTC_BIT_CAP_ARM]) begin
          cnt_reg[c] <= ev ? 8'h01 : 8'h00;
          valid_reg[c] <= valid_reg[c] | (ev && CAPTURE_STORED[c]);
        end else begin
          valid_reg[c] <= ev && CAPTURE_STORED[c];
          ovf_reg[c] <= ev && (cnt_reg[c] == 8'hff);
        end
      end else if (ev) begin
        if (cnt_reg[c] == 8'hff) begin
          ovf_reg[c] <= 1'b1;
        end else begin
          cnt_reg[c] <= cnt_reg[c] + 8'h01;
        end
        valid_reg[c] <= valid_reg[c] | CAPTURE_STORED[c];
      end
    end
    assign CAPTURE_IRQ[c] = irq_en_reg[c] && valid_reg[c];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_next;
  // Decoded from the address phase so the answer is ready for the data phase
  always_comb begin
    rd_next = `PTPTC_ZERO32;
    case (HADDR[11:0])
      `PTPTC_ADDR_INDEX: begin
        rd_next[`PTPTC_IDX_TRIG_MSB:`PTPTC_IDX_TRIG_LSB] = trig_ptr_reg;
        rd_next[`PTPTC_IDX_TS_BIT] = ts_ptr_reg;
      end
      `PTPTC_ADDR_CTRL: begin
        rd_next[`PTPTC_BIT_OUT_SEL] = out_sel_reg;
        rd_next[`PTPTC_BIT_PIN_IN] = PIN_IN;
        rd_next[`PTPTC_BIT_PIN_DIR] = pin_dir_reg;
        rd_next[`PTPTC_BIT_IRQ_EN] = irq_en_reg[ts_ptr_reg];
        rd_next[`PTPTC_BIT_RUNNING] = arm_reg[trig_ptr_reg] && !err_reg[trig_ptr_reg];
        rd_next[`PTPTC_BIT_ARM] = arm_reg[trig_ptr_reg];
        rd_next[`PTPTC_BIT_CAP_ARM] = cap_arm_reg[ts_ptr_reg];
      end
      `PTPTC_ADDR_TGT_NS: rd_next[`PTPTC_NS_MSB:0] = tns_reg[trig_ptr_reg];
      `PTPTC_ADDR_TGT_S: rd_next = ts_reg[trig_ptr_reg];
      `PTPTC_ADDR_OPTION: rd_next[`PTPTC_BIT_FIRE_NOW] = now_reg[trig_ptr_reg];
      `PTPTC_ADDR_ERROR: rd_next[`PTPTC_ERR_LSB+NT-1:`PTPTC_ERR_LSB] = err_reg;
      `PTPTC_ADDR_COUNT: begin
        rd_next[`PTPTC_CNT_OVF_BIT-1:0] = cnt_reg[ts_ptr_reg];
        rd_next[`PTPTC_CNT_OVF_BIT] = ovf_reg[ts_ptr_reg];
      end
      default: rd_next = `PTPTC_ZERO32;
    endcase
  end
  // Loaded at the address phase edge, so the word stands through the data phase.
  // Limitation: a read right behind a write to the same word sees the old value.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      HRDATA <= `PTPTC_ZERO32;
    end else if (HREADY && HSEL && !HWRITE && HTRANS == `PTPTC_HTRANS_NONSEQ) begin
      HRDATA <= rd_next;
    end
  end
endmodule
`default_nettype wire

// File: ptptc_ctl_props.sv
// Concurrent checks on the ports of the pin trigger/timestamp control
`timescale 1ns/1ps
`default_nettype none
module ptptc_ctl_props (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] SYS_TIME_SEC,
  input wire logic [29:0] SYS_TIME_NS,
  input wire logic PIN_IN,
  input wire logic PIN_OUT,
  input wire logic PIN_OE,
  input wire logic [1:0] CAPTURE_EVENT,
  input wire logic [1:0] CAPTURE_STORED,
  input wire logic [1:0] CAPTURE_IRQ
);
  logic take;
  logic wr_ctrl_reg;
  assign take = HSEL && HREADY && (HTRANS == 2'h2);
  // Marks the data phase of a control write, where HWDATA stands
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wr_ctrl_reg <= 1'b0;
    end else begin
      wr_ctrl_reg <= take && HWRITE && (HADDR[11:0] == 12'h52c);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_resp_okay: assert property (HRESP == 1'b0 && HREADYOUT == 1'b1)
    else $error("bus answer not zero-wait OKAY");
  a_reset_idle: assert property ($fell(SYS_RST) |-> PIN_OE && !PIN_OUT && CAPTURE_IRQ == 2'h0)
    else $error("pins not idle after reset");
  a_pin_level: assert property (take && !HWRITE && HADDR[11:0] == 12'h52c
    |=> HRDATA[7] == $past(PIN_IN)) else $error("pin level not returned");
  a_ctrl_clear_zero: assert property (take && !HWRITE && HADDR[11:0] == 12'h52c
    |=> {HRDATA[31:9], HRDATA[2], HRDATA[0]} == 25'h0)
    else $error("control reserved or clear bits not zero");
  a_ns_top_zero: assert property (take && !HWRITE && HADDR[11:0] == 12'h530
    |=> HRDATA[31:30] == 2'h0) else $error("nanosecond top bits not zero");
  a_dir_follows: assert property (wr_ctrl_reg |=> PIN_OE == !$past(HWDATA[6]))
    else $error("pin enable does not follow direction");
  a_dir_hold: assert property (!wr_ctrl_reg |=> $stable(PIN_OE))
    else $error("pin enable moved without a write");
  a_pulse_once: assert property (PIN_OUT |=> !PIN_OUT)
    else $error("event output longer than one cycle");
endmodule
bind ptptc_ctl ptptc_ctl_props u_ptptc_ctl_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SYS_TIME_SEC(SYS_TIME_SEC), .SYS_TIME_NS(SYS_TIME_NS), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .CAPTURE_EVENT(CAPTURE_EVENT),
  .CAPTURE_STORED(CAPTURE_STORED), .CAPTURE_IRQ(CAPTURE_IRQ));
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the pin trigger/timestamp control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [29:0] t_ns = 30'h0;
  logic [31:0] t_s = 32'h5;
  logic pin_in = 1'b1;
  logic pin_out;
  logic pin_oe;
  logic [1:0] cap_ev = 2'h0;
  logic [1:0] cap_st = 2'h0;
  logic [1:0] cap_irq;
  logic [31:0] q;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int lat [2];
  always #12.5 sys_clk = ~sys_clk;
  ptptc_ctl u_ptptc_ctl (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SYS_TIME_SEC(t_s),
    .SYS_TIME_NS(t_ns), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .CAPTURE_EVENT(cap_ev), .CAPTURE_STORED(cap_st), .CAPTURE_IRQ(cap_irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Entered just after an edge; leaves at the edge that ends the data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic evt;
    cap_ev <= 2'h1;
    cap_st <= 2'h1;
    @(posedge sys_clk);
    cap_ev <= 2'h0;
    cap_st <= 2'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd("ctrl_rst", 12'h52c, 32'h80);
    chk("oe_rst", 32'h1, {31'h0, pin_oe});
    rd("ns_rst", 12'h530, 32'h0);
    rd("s_rst", 12'h534, 32'h0);
    for (int u = 0; u < 4; u++) begin
      bus(1'b1, 12'h520, 32'(u));
      bus(1'b1, 12'h530, 32'hffff_ff00 | 32'(u));
      bus(1'b1, 12'h534, 32'h5a00_0000 | 32'(u));
    end
    for (int u = 0; u < 4; u++) begin
      bus(1'b1, 12'h520, 32'(u));
      rd("tgt_ns", 12'h530, 32'h3fff_ff00 | 32'(u));
      rd("tgt_s", 12'h534, 32'h5a00_0000 | 32'(u));
    end
    bus(1'b1, 12'h520, 32'h0);
    bus(1'b1, 12'h530, 32'd100);
    bus(1'b1, 12'h534, 32'h5);
    // Same target in both source modes; the flopped copy must lag by one cycle
    for (int m = 0; m < 2; m++) begin
      t_ns <= 30'h0;
      bus(1'b1, 12'h52c, 32'h8 | 32'(m << 8));
      rd("armed", 12'h52c, 32'h98 | 32'(m << 8));
      t_ns <= 30'd100;
      lat[m] = 0;
      while (pin_out !== 1'b1 && lat[m] < 40) begin
        @(posedge sys_clk);
        #1;
        lat[m]++;
      end
      chk("fired", 32'h1, {31'h0, pin_out});
      rd("done", 12'h52c, 32'h80 | 32'(m << 8));
    end
    chk("src_lag", 32'(lat[1] + 1), 32'(lat[0]));
    // Target behind the time without fire-now: flagged, armed but not running
    bus(1'b1, 12'h530, 32'd50);
    bus(1'b1, 12'h52c, 32'h8);
    rd("late_run", 12'h52c, 32'h88);
    rd("late_err", 12'h53c, 32'h1_0000);
    bus(1'b1, 12'h52c, 32'h0);
    rd("err_clr", 12'h53c, 32'h0);
    bus(1'b1, 12'h538, 32'h200_0000);
    bus(1'b1, 12'h52c, 32'h108);
    @(posedge sys_clk);
    #1;
    chk("fire_now", 32'h1, {31'h0, pin_out});
    rd("now_done", 12'h52c, 32'h180);
    // Seconds decide before nanoseconds
    bus(1'b1, 12'h534, 32'h6);
    bus(1'b1, 12'h530, 32'h0);
    bus(1'b1, 12'h52c, 32'h108);
    rd("sec_wait", 12'h52c, 32'h198);
    t_s <= 32'h6;
    @(posedge sys_clk);
    #1;
    chk("sec_fire", 32'h1, {31'h0, pin_out});
    bus(1'b1, 12'h52c, 32'h4);
    rd("tclr_s", 12'h534, 32'h0);
    rd("tclr_opt", 12'h538, 32'h0);
    bus(1'b1, 12'h52c, 32'h62);
    @(posedge sys_clk);
    chk("oe_in", 32'h0, {31'h0, pin_oe});
    evt();
    chk("irq_on", 32'h1, {30'h0, cap_irq});
    rd("count", 12'h540, 32'h1);
    bus(1'b1, 12'h52c, 32'h60);
    rd("ctrl_off", 12'h52c, 32'he0);
    chk("irq_off", 32'h0, {30'h0, cap_irq});
    bus(1'b1, 12'h52c, 32'h42);
    rd("count_clr", 12'h540, 32'h0);
    evt();
    chk("irq_mask", 32'h0, {30'h0, cap_irq});
    rd("count_one", 12'h540, 32'h1);
    bus(1'b1, 12'h520, 32'h100);
    rd("ts_unit1", 12'h52c, 32'hc0);
    bus(1'b1, 12'h520, 32'h0);
    bus(1'b1, 12'h52c, 32'h63);
    rd("cclr", 12'h52c, 32'hc0);
    rd("cclr_cnt", 12'h540, 32'h0);
    rd("unmapped", 12'h600, 32'h0);
    pin_in <= 1'b0;
    rd("pin_low", 12'h52c, 32'h40);
    close_out();
  end
endmodule
`default_nettype wire
